// ===== cris_defs.svh
`ifndef CRIS_DEFS_SVH
`define CRIS_DEFS_SVH

// ----------------------------------------------------------------
// register map (byte addresses, word aligned)
// ----------------------------------------------------------------
`define CRIS_OFF_CTRL      8'h00
`define CRIS_OFF_STATUS    8'h04
`define CRIS_OFF_STRAPS    8'h08
`define CRIS_OFF_IP        8'h0c
`define CRIS_OFF_FLAGS     8'h10
`define CRIS_OFF_ACC       8'h14
`define CRIS_OFF_DATAEXT   8'h18
`define CRIS_OFF_CR0       8'h1c
`define CRIS_OFF_DBGCTRL   8'h20
`define CRIS_OFF_DBGSTAT   8'h24
`define CRIS_OFF_FPCTRL    8'h28
`define CRIS_OFF_FPTAG     8'h2c
`define CRIS_OFF_CSSEL     8'h30
`define CRIS_OFF_DTLIMIT   8'h34
`define CRIS_OFF_TSC_LO    8'h38
`define CRIS_OFF_TSC_HI    8'h3c
`define CRIS_OFF_WRITE_HANDLING_CTRL_REG_LO   8'h40
`define CRIS_OFF_MCA_LO    8'h44
`define CRIS_OFF_SCRATCH   8'h48

// ----------------------------------------------------------------
// control / status field positions
// ----------------------------------------------------------------
`define CRIS_CTRL_BOUNDARY 0
`define CRIS_CTRL_NMI_SET  1
`define CRIS_CTRL_SELFFAIL 2
`define CRIS_ST_NMI        0
`define CRIS_ST_FLUSH      1
`define CRIS_ST_SMI        2
`define CRIS_ST_INIT_PEND  3
`define CRIS_ST_RUN        4
`define CRIS_ST_TRI_TEST   5
`define CRIS_CR0_NW        29
`define CRIS_CR0_CD        30

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CRIS_RST_IP        32'hffff_fff0
`define CRIS_RST_FLAGS     32'h0000_0002
`define CRIS_RST_CS        16'hf000
`define CRIS_RST_DTLIMIT   16'hffff
`define CRIS_RST_CR0       32'h6000_0010
`define CRIS_RST_DBGCTRL   32'h0000_0400
`define CRIS_RST_DBGSTAT   32'hffff_0ff0
`define CRIS_RST_FPCTRL    16'h0040
`define CRIS_RST_FPTAG     16'h5555
`define CRIS_SELF_FAIL     32'h0000_0001
`define CRIS_SIGNATURE     28'h0000_abc

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CRIS_CLK_NS        100
`define CRIS_WARM_CLOCKS   15
`define CRIS_POR_NS        1000000
`define CRIS_POR_CYC       ((`CRIS_POR_NS + `CRIS_CLK_NS - 1) / `CRIS_CLK_NS)
`define CRIS_INIT_CYC      8
`define CRIS_BUILTIN_SELF_TEST_CYC      16

`endif

// ===== cris_pkg.sv
package cris_pkg;

  typedef enum logic [4:0] {
    CRIS_ST_RESET = 5'b00001,
    CRIS_ST_BUILTIN_SELF_TEST  = 5'b00010,
    CRIS_ST_RUN   = 5'b00100,
    CRIS_ST_INIT  = 5'b01000,
    CRIS_ST_TRIST = 5'b10000
  } cris_state_t;

endpackage : cris_pkg

// ===== cris_sync.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// two-flop synchroniser per bit
// ----------------------------------------------------------------
module cris_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      // reset value is a constant 1 on every bit; rst_val_i from the parent is not used
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          meta_reg[gi] <= 1'b1;
          sync_o[gi]   <= 1'b1;
        end else begin
          meta_reg[gi] <= async_i[gi];
          sync_o[gi]   <= meta_reg[gi];
        end
      end
    end
  endgenerate

  logic unused_rst;
  assign unused_rst = |rst_val_i;
endmodule : cris_sync

// ===== cris_avs.sv
`timescale 1ns/1ps
`include "cris_defs.svh"
// ----------------------------------------------------------------
// avalon-mm slave front end: one wait state on every access
// ----------------------------------------------------------------
module cris_avs (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  output logic             avs_waitrequest_o,
  output logic             rd_stb_o,
  output logic             wr_stb_o
);
  logic ack_reg;

  // first cycle of a request waits, second completes it
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
    end
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign rd_stb_o          = avs_read_i & ack_reg;
  assign wr_stb_o          = avs_write_i & ack_reg;

  logic unused_addr;
  assign unused_addr = |avs_address_i;
endmodule : cris_avs

// ===== cris_seq.sv
`timescale 1ns/1ps
`include "cris_defs.svh"

module cris_seq #(
  parameter int unsigned STEPPING = 4'h0,
  parameter int unsigned BUILTIN_SELF_TEST_CYC = `CRIS_BUILTIN_SELF_TEST_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        hard_reset_i,
  input  wire logic        soft_init_i,
  input  wire logic        flush_n_i,
  input  wire logic        sys_mgmt_irq_n_i,
  input  wire logic        nmi_i,
  input  wire logic [2:0]  bus_ratio_sel_i,
  input  wire logic        burst_ready_copy_n_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic [2:0]       core_ratio_o,
  output logic             strong_drive_o,
  output logic             tri_test_o,
  output logic             fetch_start_o,
  output logic             bus_float_o,
  output logic             strobes_high_o,
  output logic             cycle_defs_low_o,
  output logic             cache_flush_req_o,
  output logic             sys_mgmt_req_o
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] raw_pins;
  logic [6:0] syn_pins;
  assign raw_pins = {hard_reset_i, soft_init_i, flush_n_i,
                     sys_mgmt_irq_n_i, nmi_i, burst_ready_copy_n_i,
                     bus_ratio_sel_i[0]};

  cris_sync #(.WIDTH(7)) u_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .async_i   (raw_pins),
    .rst_val_i (7'h7f),
    .sync_o    (syn_pins)
  );

  logic [1:0] ratio_meta_reg;
  logic [1:0] ratio_hi_reg;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ratio_meta_reg <= 2'h0;
      ratio_hi_reg   <= 2'h0;
    end else begin
      ratio_meta_reg <= bus_ratio_sel_i[2:1];
      ratio_hi_reg   <= ratio_meta_reg;
    end
  end

  logic hard_s, init_s, flush_n_s, smi_n_s, nmi_s, burst_ready_copy_n_n_s;
  assign hard_s    = syn_pins[6];
  assign init_s    = syn_pins[5];
  assign flush_n_s = syn_pins[4];
  assign smi_n_s   = syn_pins[3];
  assign nmi_s     = syn_pins[2];
  assign burst_ready_copy_n_n_s = syn_pins[1];

  logic hard_d_reg, flush_d_reg, smi_d_reg;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hard_d_reg  <= 1'b1;
      flush_d_reg <= 1'b1;
      smi_d_reg   <= 1'b1;
    end else begin
      hard_d_reg  <= hard_s;
      flush_d_reg <= flush_n_s;
      smi_d_reg   <= smi_n_s;
    end
  end

  logic reset_fall, flush_edge, smi_edge;
  assign reset_fall = hard_d_reg & ~hard_s;
  assign flush_edge = flush_d_reg & ~flush_n_s;
  assign smi_edge   = smi_d_reg & ~smi_n_s;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic rd_stb, wr_stb;
  cris_avs u_avs (
    .sys_clk_i         (sys_clk_i),
    .resetn_i          (resetn_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_waitrequest_o (avs_waitrequest_o),
    .rd_stb_o          (rd_stb),
    .wr_stb_o          (wr_stb)
  );

  logic [31:0] ctrl_reg;
  logic [31:0] scratch_reg;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg    <= 32'h0;
      scratch_reg <= 32'h0;
    end else if (wr_stb && avs_address_i == `CRIS_OFF_CTRL) begin
      ctrl_reg <= avs_writedata_i;
    end else if (wr_stb && avs_address_i == `CRIS_OFF_SCRATCH) begin
      scratch_reg <= avs_writedata_i;
    end else begin
      // nmi raise bit is self clearing
      ctrl_reg[`CRIS_CTRL_NMI_SET] <= 1'b0;
    end
  end
  logic boundary;
  assign boundary = ctrl_reg[`CRIS_CTRL_BOUNDARY];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  cris_pkg::cris_state_t state_reg;
  logic [15:0] cnt_reg;
  logic        init_pend_reg;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= cris_pkg::CRIS_ST_RESET;
      cnt_reg   <= 16'h0;
    end else if (hard_s) begin
      state_reg <= cris_pkg::CRIS_ST_RESET;
      cnt_reg   <= 16'h0;
    end else begin
      case (state_reg)
        cris_pkg::CRIS_ST_RESET: begin
          if (reset_fall) begin
            state_reg <= flush_n_s ? cris_pkg::CRIS_ST_BUILTIN_SELF_TEST
                                   : cris_pkg::CRIS_ST_TRIST;
          end
          cnt_reg <= 16'h0;
        end
        cris_pkg::CRIS_ST_BUILTIN_SELF_TEST: begin
          if (cnt_reg == 16'(BUILTIN_SELF_TEST_CYC - 1)) begin
            state_reg <= cris_pkg::CRIS_ST_RUN;
            cnt_reg   <= 16'h0;
          end else begin
            cnt_reg <= cnt_reg + 16'h1;
          end
        end
        cris_pkg::CRIS_ST_RUN: begin
          if (init_pend_reg && boundary) begin
            state_reg <= cris_pkg::CRIS_ST_INIT;
            cnt_reg   <= 16'h0;
          end
        end
        cris_pkg::CRIS_ST_INIT: begin
          if (cnt_reg == 16'(`CRIS_INIT_CYC - 1)) begin
            state_reg <= cris_pkg::CRIS_ST_RUN;
            cnt_reg   <= 16'h0;
          end else begin
            cnt_reg <= cnt_reg + 16'h1;
          end
        end
        cris_pkg::CRIS_ST_TRIST: begin
          cnt_reg <= 16'h0;
        end
        default: begin
          state_reg <= cris_pkg::CRIS_ST_RESET;
          cnt_reg   <= 16'h0;
        end
      endcase
    end
  end

  logic init_done;
  assign init_done = (state_reg == cris_pkg::CRIS_ST_INIT) &&
                     (cnt_reg == 16'(`CRIS_INIT_CYC - 1));
  logic init_go;
  assign init_go = (state_reg == cris_pkg::CRIS_ST_RUN) &&
                   init_pend_reg && boundary;
  logic builtin_self_test_done;
  assign builtin_self_test_done = (state_reg == cris_pkg::CRIS_ST_BUILTIN_SELF_TEST) &&
                     (cnt_reg == 16'(BUILTIN_SELF_TEST_CYC - 1));

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      init_pend_reg <= 1'b0;
    end else if (hard_s) begin
      init_pend_reg <= 1'b0;
    end else if (init_s) begin
      init_pend_reg <= 1'b1;
    end else if (init_go) begin
      init_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // straps
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_ratio_o   <= 3'h0;
      strong_drive_o <= 1'b0;
      tri_test_o     <= 1'b0;
    end else if (reset_fall) begin
      core_ratio_o   <= {ratio_hi_reg, syn_pins[0]};
      strong_drive_o <= ~burst_ready_copy_n_n_s;
      tri_test_o     <= ~flush_n_s;
    end
  end

  // ----------------------------------------------------------------
  // pin states and pending events
  // ----------------------------------------------------------------
  logic in_reset;
  assign in_reset = hard_s || (state_reg == cris_pkg::CRIS_ST_RESET);
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_float_o      <= 1'b1;
      strobes_high_o   <= 1'b1;
      cycle_defs_low_o <= 1'b1;
      fetch_start_o    <= 1'b0;
    end else begin
      bus_float_o      <= in_reset ||
                          state_reg == cris_pkg::CRIS_ST_TRIST;
      strobes_high_o   <= in_reset;
      cycle_defs_low_o <= in_reset;
      fetch_start_o    <= (builtin_self_test_done || init_done) && !hard_s;
    end
  end

  logic nmi_pend_reg, flush_pend_reg, smi_pend_reg;
  logic serve;
  assign serve = (state_reg == cris_pkg::CRIS_ST_RUN) && boundary &&
                 rd_stb && avs_address_i == `CRIS_OFF_STATUS;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      nmi_pend_reg   <= 1'b0;
      flush_pend_reg <= 1'b0;
      smi_pend_reg   <= 1'b0;
    end else if (hard_s) begin
      nmi_pend_reg   <= 1'b0;
      flush_pend_reg <= 1'b0;
      smi_pend_reg   <= 1'b0;
    end else begin
      if (init_s) begin
        nmi_pend_reg <= 1'b0;
      end else if (nmi_s || ctrl_reg[`CRIS_CTRL_NMI_SET]) begin
        nmi_pend_reg <= 1'b1;
      end else if (serve) begin
        nmi_pend_reg <= 1'b0;
      end
      if (flush_edge) begin
        flush_pend_reg <= 1'b1;
      end else if (serve) begin
        flush_pend_reg <= 1'b0;
      end
      if (smi_edge) begin
        smi_pend_reg <= 1'b1;
      end else if (serve) begin
        smi_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cache_flush_req_o <= 1'b0;
      sys_mgmt_req_o    <= 1'b0;
    end else begin
      cache_flush_req_o <= flush_pend_reg &&
                           state_reg == cris_pkg::CRIS_ST_RUN;
      sys_mgmt_req_o    <= smi_pend_reg &&
                           state_reg == cris_pkg::CRIS_ST_RUN;
    end
  end

  // ----------------------------------------------------------------
  // architectural state
  // ----------------------------------------------------------------
  logic [31:0] instr_pointer_reg, flags_reg, accumulator_reg;
  logic [31:0] data_ext_reg, ctrl_reg_zero, debug_ctrl_reg;
  logic [31:0] debug_status_reg;
  logic [15:0] code_sel_reg, fp_ctrl_reg, fp_tag_reg, dt_limit_reg;
  logic [63:0] time_stamp_counter, write_handling_ctrl_reg;
  logic [63:0] machine_check_addr_reg;

  logic arch_load;
  assign arch_load = in_reset || init_go;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      instr_pointer_reg <= `CRIS_RST_IP;
      flags_reg         <= `CRIS_RST_FLAGS;
      code_sel_reg      <= `CRIS_RST_CS;
      dt_limit_reg      <= `CRIS_RST_DTLIMIT;
      debug_ctrl_reg    <= `CRIS_RST_DBGCTRL;
      debug_status_reg  <= `CRIS_RST_DBGSTAT;
      data_ext_reg      <= 32'h0;
    end else if (arch_load) begin
      instr_pointer_reg <= `CRIS_RST_IP;
      flags_reg         <= `CRIS_RST_FLAGS;
      code_sel_reg      <= `CRIS_RST_CS;
      dt_limit_reg      <= `CRIS_RST_DTLIMIT;
      debug_ctrl_reg    <= `CRIS_RST_DBGCTRL;
      debug_status_reg  <= `CRIS_RST_DBGSTAT;
      data_ext_reg      <= {`CRIS_SIGNATURE, 4'(STEPPING)};
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      accumulator_reg <= 32'h0;
    end else if (arch_load) begin
      accumulator_reg <= 32'h0;
    end else if (builtin_self_test_done) begin
      accumulator_reg <= ctrl_reg[`CRIS_CTRL_SELFFAIL] ? `CRIS_SELF_FAIL
                                                       : 32'h0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg_zero <= `CRIS_RST_CR0;
    end else if (in_reset) begin
      ctrl_reg_zero <= `CRIS_RST_CR0;
    end else if (init_go) begin
      ctrl_reg_zero <= (`CRIS_RST_CR0 & ~32'h6000_0000) |
                       (ctrl_reg_zero & 32'h6000_0000);
    end else if (wr_stb && avs_address_i == `CRIS_OFF_CR0) begin
      ctrl_reg_zero <= avs_writedata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fp_ctrl_reg             <= `CRIS_RST_FPCTRL;
      fp_tag_reg              <= `CRIS_RST_FPTAG;
      time_stamp_counter      <= 64'h0;
      write_handling_ctrl_reg <= 64'h0;
      machine_check_addr_reg  <= 64'h0;
    end else if (in_reset) begin
      fp_ctrl_reg             <= `CRIS_RST_FPCTRL;
      fp_tag_reg              <= `CRIS_RST_FPTAG;
      time_stamp_counter      <= 64'h0;
      write_handling_ctrl_reg <= 64'h0;
      machine_check_addr_reg  <= 64'h0;
    end else begin
      // soft init leaves these untouched
      time_stamp_counter <= time_stamp_counter + 64'h1;
      if (wr_stb && avs_address_i == `CRIS_OFF_WRITE_HANDLING_CTRL_REG_LO) begin
        write_handling_ctrl_reg[31:0] <= avs_writedata_i;
      end
      if (wr_stb && avs_address_i == `CRIS_OFF_MCA_LO) begin
        machine_check_addr_reg[31:0] <= avs_writedata_i;
      end
      if (wr_stb && avs_address_i == `CRIS_OFF_FPCTRL) begin
        fp_ctrl_reg <= avs_writedata_i[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address_i)
      `CRIS_OFF_CTRL:    rd_mux = ctrl_reg;
      `CRIS_OFF_STATUS:  rd_mux = {26'h0, tri_test_o,
                                   state_reg == cris_pkg::CRIS_ST_RUN,
                                   init_pend_reg, smi_pend_reg,
                                   flush_pend_reg, nmi_pend_reg};
      `CRIS_OFF_STRAPS:  rd_mux = {27'h0, core_ratio_o, strong_drive_o,
                                  tri_test_o};
      `CRIS_OFF_IP:      rd_mux = instr_pointer_reg;
      `CRIS_OFF_FLAGS:   rd_mux = flags_reg;
      `CRIS_OFF_ACC:     rd_mux = accumulator_reg;
      `CRIS_OFF_DATAEXT: rd_mux = data_ext_reg;
      `CRIS_OFF_CR0:     rd_mux = ctrl_reg_zero;
      `CRIS_OFF_DBGCTRL: rd_mux = debug_ctrl_reg;
      `CRIS_OFF_DBGSTAT: rd_mux = debug_status_reg;
      `CRIS_OFF_FPCTRL:  rd_mux = {16'h0, fp_ctrl_reg};
      `CRIS_OFF_FPTAG:   rd_mux = {16'h0, fp_tag_reg};
      `CRIS_OFF_CSSEL:   rd_mux = {16'h0, code_sel_reg};
      `CRIS_OFF_DTLIMIT: rd_mux = {16'h0, dt_limit_reg};
      `CRIS_OFF_TSC_LO:  rd_mux = time_stamp_counter[31:0];
      `CRIS_OFF_TSC_HI:  rd_mux = time_stamp_counter[63:32];
      `CRIS_OFF_WRITE_HANDLING_CTRL_REG_LO: rd_mux = write_handling_ctrl_reg[31:0];
      `CRIS_OFF_MCA_LO:  rd_mux = machine_check_addr_reg[31:0];
      `CRIS_OFF_SCRATCH: rd_mux = scratch_reg;
      default:           rd_mux = 32'h0;
    endcase
  end

  // readdata is registered; valid at the completing edge
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= 32'h0;
    end else begin
      avs_readdata_o <= rd_mux;
    end
  end
endmodule : cris_seq

// ===== cris_seq_assertions.sv
`timescale 1ns/1ps
// ----------------------------
// sequencer port checker
// ----------------------------
module cris_seq_chk (
  input wire logic       sys_clk_i,
  input wire logic       resetn_i,
  input wire logic       hard_reset_i,
  input wire logic       flush_n_i,
  input wire logic [2:0] bus_ratio_sel_i,
  input wire logic       burst_ready_copy_n_i,
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       avs_waitrequest_o,
  input wire logic [2:0] core_ratio_o,
  input wire logic       strong_drive_o,
  input wire logic       tri_test_o,
  input wire logic       fetch_start_o,
  input wire logic       bus_float_o,
  input wire logic       strobes_high_o,
  input wire logic       cycle_defs_low_o,
  input wire logic       sys_mgmt_req_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // quiet clocks since hard reset; saturates so straps are judged once
  logic [2:0] quiet_reg;
  always_ff @(posedge sys_clk_i or negedge resetn_i)
    if (!resetn_i) quiet_reg <= 3'h0;
    else if (hard_reset_i) quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
  chk_wait_one: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("wait too long");
  chk_wait_idle: assert property (!avs_read_i && !avs_write_i |->
    !avs_waitrequest_o) else $error("wait while idle");
  chk_pin_levels: assert property (
    $rose(hard_reset_i) |-> ##[1:4] bus_float_o && strobes_high_o &&
    cycle_defs_low_o) else $error("reset pin levels");
  chk_strap_take: assert property (
    quiet_reg == 3'h6 |-> core_ratio_o == bus_ratio_sel_i && strong_drive_o
    == !burst_ready_copy_n_i && tri_test_o == !flush_n_i) else $error("strap");
  chk_strap_hold: assert property (
    quiet_reg == 3'h7 |-> $stable(core_ratio_o) && $stable(strong_drive_o)
    && $stable(tri_test_o)) else $error("strap moved");
  chk_fetch_pulse: assert property (
    fetch_start_o |=> !fetch_start_o) else $error("fetch pulse");
  chk_tri_nofetch: assert property (
    tri_test_o |-> !fetch_start_o) else $error("fetch in test mode");
  chk_smi_keep: assert property (
    sys_mgmt_req_o && !avs_read_i && !$past(avs_read_i) && quiet_reg == 3'h7
    |=> sys_mgmt_req_o) else $error("smi request lost");
  cover property (fetch_start_o);
  cover property (tri_test_o);
  cover property (sys_mgmt_req_o);
endmodule : cris_seq_chk

bind cris_seq cris_seq_chk u_chk (.*);

// ===== cris_sys_model.sv
`timescale 1ns/1ps
// ----------------------------
// system logic driving reset and init
// ----------------------------
module cris_sys_model (
  input  wire logic       sys_clk_i,
  output logic            hard_reset_i = 1'b1,
  output logic            soft_init_i = 1'b0,
  output logic            flush_n_i = 1'b1,
  output logic            sys_mgmt_irq_n_i = 1'b1,
  output logic            nmi_i = 1'b0,
  output logic [2:0]      bus_ratio_sel_i = 3'h0,
  output logic            burst_ready_copy_n_i = 1'b1
);
  // held for the caller's count; straps steady past the fall
  task automatic hard_reset(input logic [2:0] r, input logic b, f,
                            input int hold);
    @(posedge sys_clk_i);
    hard_reset_i <= 1'b1;
    bus_ratio_sel_i <= r;
    burst_ready_copy_n_i <= b;
    flush_n_i <= f;
    repeat (hold) @(posedge sys_clk_i);
    hard_reset_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    flush_n_i <= 1'b1;
  endtask : hard_reset
  // two low then two high suits either timing
  task automatic soft_init();
    repeat (2) @(posedge sys_clk_i);
    soft_init_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    soft_init_i <= 1'b0;
  endtask : soft_init
  task automatic irq(input logic smi);
    @(posedge sys_clk_i);
    // edge requests come as a pair: flush and sys-mgmt fall together
    if (smi) begin
      sys_mgmt_irq_n_i <= 1'b0;
      flush_n_i <= 1'b0;
    end else begin
      nmi_i <= 1'b1;
    end
    repeat (2) @(posedge sys_clk_i);
    sys_mgmt_irq_n_i <= 1'b1;
    flush_n_i <= 1'b1;
    nmi_i <= 1'b0;
  endtask : irq
endmodule : cris_sys_model

// ===== cpu_reset_init_sequencer_tb.sv
`timescale 1ns/1ps
`include "cris_defs.svh"
// ----------------------------
// sequencer bench
// ----------------------------
module cpu_reset_init_sequencer_tb;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [7:0]  avs_address_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0;
  wire  [31:0] avs_readdata_o;
  wire  [2:0]  core_ratio_o, bus_ratio_sel_i;
  wire         avs_waitrequest_o, strong_drive_o, tri_test_o, fetch_start_o;
  wire         bus_float_o, strobes_high_o, cycle_defs_low_o, nmi_i;
  wire         cache_flush_req_o, sys_mgmt_req_o, hard_reset_i, soft_init_i;
  wire         flush_n_i, sys_mgmt_irq_n_i, burst_ready_copy_n_i;
  int          fail_count = 0, n_tests = 0, cyc = 0, k;
  logic [31:0] seed, r, v, q;
  logic [7:0]  ra [8] = '{8'h0c, 8'h10, 8'h14, 8'h1c, 8'h20, 8'h24, 8'h28,
                          8'h2c};
  logic [31:0] rv [8] = '{32'hffff_fff0, 32'h2, 32'h0, 32'h6000_0010,
                          32'h400, 32'hffff_0ff0, 32'h40, 32'h5555};
  cris_seq #(.STEPPING(4'h5)) dut (.*);
  cris_sys_model sys (.*);
  initial forever #50 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    @(posedge sys_clk_i iff !avs_waitrequest_o);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task automatic wait_fetch();
    for (k = 0; k < 200 && fetch_start_o !== 1'b1; k++) @(posedge sys_clk_i);
    chk({31'h0, fetch_start_o}, 32'h1);
  endtask : wait_fetch
  task automatic wrap_up();
    $display("tests %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // hang guard: the 10k-clock power-on hold dominates the run
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    seed = 32'hf86c;
    r = $random(seed);
    v = $random(seed);
    repeat (10) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    sys.hard_reset(r[2:0], r[3], 1'b1, `CRIS_POR_CYC);
    wait_fetch();
    bus(0, 8'h08, 0);
    chk(q & 32'h1f, {27'h0, r[2:0], ~r[3], 1'b0});
    for (int i = 0; i < 8; i++) begin
      bus(0, ra[i], 0);
      chk(q, rv[i]);
    end
    bus(0, 8'h18, 0);
    chk(q & 32'hf, 32'h5);
    bus(1, 8'h40, v);
    bus(1, 8'h28, 32'h037f);
    bus(1, 8'h1c, 32'h1);
    sys.irq(1'b0);
    sys.soft_init();
    bus(1, 8'h00, 32'h1);
    sys.irq(1'b1);
    wait_fetch();
    bus(0, 8'h04, 0);
    chk(q & 32'h7, 32'h6);
    chk({30'h0, cache_flush_req_o, sys_mgmt_req_o}, 32'h3);
    bus(0, 8'h40, 0);
    chk(q, v);
    bus(0, 8'h28, 0);
    chk(q, 32'h037f);
    bus(0, 8'h1c, 0);
    chk(q, 32'h10);
    sys.hard_reset(~r[2:0], ~r[3], 1'b0, 16);
    bus(0, 8'h40, 0);
    chk(q, 32'h0);
    bus(0, 8'h04, 0);
    chk(q & 32'h20, 32'h20);
    // forced self-test failure, then a warm reset into self-test
    bus(1, 8'h00, 32'h4);
    sys.hard_reset(r[2:0], r[3], 1'b1, 16);
    wait_fetch();
    bus(0, 8'h14, 0);
    chk({31'h0, q != 32'h0}, 32'h1);
    bus(0, 8'hfc, 0);
    chk(q, 32'h0);
    wrap_up();
  end
endmodule : cpu_reset_init_sequencer_tb
